// >>> src/adc_ctrl_pkg.sv
// Shared constants and types of the converter control block
package adc_ctrl_pkg;

	// Clock and timing
	localparam int CLK_PERIOD_NS   = 20;
	localparam int CONV_TIME_NS    = 527;
	localparam int SYNC_LAT_CYCLES = 3;
	// Longest time rounds down; pin synchroniser latency is taken out of the budget
	localparam int CONV_CYCLES     = CONV_TIME_NS / CLK_PERIOD_NS - SYNC_LAT_CYCLES;
	localparam int POR_WAIT_US     = 200;
	localparam int POR_WAIT_CYCLES = (POR_WAIT_US * 1000) / CLK_PERIOD_NS;

	// Host-side timing, kept for reference; neither the bench nor the checks use it
	localparam int CNV_GLITCH_NS   = 40;
	localparam int ACQ_MIN_NS      = 460;
	localparam int SCK_MIN_MHZ     = 40;

	// Widths
	localparam int RESULT_W        = 16;
	localparam int EDGE_CNT_W      = 8;
	localparam int CONV_CNT_W      = 5;
	localparam int POR_CNT_W       = 14;
	localparam int CHAIN_DELAY     = 16;

	// Reset values
	localparam logic [RESULT_W-1:0] RESULT_RST = 16'h0000;

	typedef enum logic [3:0] {
		ST_INIT  = 4'h1,
		ST_ACQ   = 4'h2,
		ST_CONV  = 4'h4,
		ST_SLEEP = 4'h8
	} conv_state_t;

endpackage

// >>> src/sync2.sv
// Two-flop synchroniser for levels and gray-coded words
`timescale 1ns/100ps
module sync2 #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             arst_n,
	// Data
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);

	logic [WIDTH-1:0] meta_r;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			meta_r <= '0;
			q      <= '0;
		end else begin
			meta_r <= d;
			q      <= meta_r;
		end
	end

endmodule

// >>> src/link_shifter.sv
// Serial readout logic running on the host shift clock
`timescale 1ns/100ps
module link_shifter (
	// Link clock and reset
	input  wire logic                                     sck,
	input  wire logic                                     arst_n,
	// Serial pins
	input  wire logic                                     sdi,
	output logic                                          sdo,
	// Quasi-static from the system domain
	input  wire logic                                     chain_mode,
	input  wire logic [adc_ctrl_pkg::RESULT_W-1:0]        result,
	input  wire logic [adc_ctrl_pkg::EDGE_CNT_W-1:0]      mark,
	// Edge count to the system domain
	output logic      [adc_ctrl_pkg::EDGE_CNT_W-1:0]      edge_gray
);

	logic [adc_ctrl_pkg::EDGE_CNT_W-1:0]  cnt_r;
	logic [adc_ctrl_pkg::EDGE_CNT_W-1:0]  cnt_nxt;
	logic [adc_ctrl_pkg::EDGE_CNT_W-1:0]  idx_nxt;
	logic [adc_ctrl_pkg::CHAIN_DELAY-1:0] dly_r;
	logic                                 sdo_r;

	assign cnt_nxt = cnt_r + 8'h01;
	assign idx_nxt = cnt_nxt - mark;

	always_ff @(posedge sck or negedge arst_n) begin
		if (!arst_n) begin
			cnt_r     <= '0;
			edge_gray <= '0;
		end else begin
			cnt_r     <= cnt_nxt;
			edge_gray <= cnt_nxt ^ (cnt_nxt >> 1);
		end
	end

	// Upstream data taken on every rising edge
	always_ff @(posedge sck or negedge arst_n) begin
		if (!arst_n) begin
			dly_r <= '0;
		end else begin
			dly_r <= {dly_r[adc_ctrl_pkg::CHAIN_DELAY-2:0], sdi};
		end
	end

	// Next bit presented on each rising edge
	always_ff @(posedge sck or negedge arst_n) begin
		if (!arst_n) begin
			sdo_r <= 1'b0;
		end else if (idx_nxt < 8'h10) begin
			sdo_r <= result[4'hF - idx_nxt[3:0]];
		end else begin
			sdo_r <= chain_mode & dly_r[adc_ctrl_pkg::CHAIN_DELAY-2];
		end
	end

	// Most significant bit stands until the first edge after a new result
	assign sdo = (cnt_r == mark) ? result[adc_ctrl_pkg::RESULT_W-1] : sdo_r;

endmodule

// >>> src/adc_conv_ctrl.sv
// Conversion control and serial readout of a 16-bit SAR converter
`timescale 1ns/100ps
module adc_conv_ctrl #(
	parameter int unsigned POR_WAIT_CYCLES = adc_ctrl_pkg::POR_WAIT_CYCLES
) (
	// System clock and reset
	input  wire logic                              clk_sys,
	input  wire logic                              arst_n,
	// Link clock from the host
	input  wire logic                              sck,
	// Control pins
	input  wire logic                              conversion_start,
	input  wire logic                              readout_select_or_chain_input,
	input  wire logic                              chain_mode,
	// Supply monitor and converter core
	input  wire logic                              supply_ok,
	input  wire logic [adc_ctrl_pkg::RESULT_W-1:0] sar_result,
	output logic                                   core_power_on,
	output logic                                   standby,
	output logic                                   init_done,
	// Status and serial output
	output logic                                   busy,
	output logic                                   sdo,
	output logic                                   sdo_oe_n
);

	// Pins synchronised into the system domain
	logic [3:0]                              pins_raw;
	logic [3:0]                              pins_s;
	logic                                    cnv_s;
	logic                                    sel_s;
	logic                                    chain_s;
	logic                                    supply_s;

	// Link edge count
	logic [adc_ctrl_pkg::EDGE_CNT_W-1:0]     edge_gray;
	logic [adc_ctrl_pkg::EDGE_CNT_W-1:0]     gray_s;
	logic [adc_ctrl_pkg::EDGE_CNT_W-1:0]     gray_prev_r;
	logic [adc_ctrl_pkg::EDGE_CNT_W-1:0]     mark_r;
	logic                                    sck_edge;

	// Control
	adc_ctrl_pkg::conv_state_t               state_r;
	adc_ctrl_pkg::conv_state_t               state_nxt;
	logic [adc_ctrl_pkg::CONV_CNT_W-1:0]     conv_cnt_r;
	logic [adc_ctrl_pkg::POR_CNT_W-1:0]      por_cnt_r;
	logic                                    cnv_prev_r;
	logic                                    cnv_rise;
	logic                                    conv_done;
	logic                                    por_done;
	logic [1:0]                              pulse_cnt_r;
	logic                                    sleep_req_r;
	logic [adc_ctrl_pkg::RESULT_W-1:0]       result_r;
	logic                                    oe_n_r;
	logic                                    chain_r;

	localparam logic [adc_ctrl_pkg::CONV_CNT_W-1:0] CONV_LAST =
		adc_ctrl_pkg::CONV_CNT_W'(adc_ctrl_pkg::CONV_CYCLES - 1);

	// Gray to binary for the edge count
	function automatic logic [adc_ctrl_pkg::EDGE_CNT_W-1:0] gray2bin(
		input logic [adc_ctrl_pkg::EDGE_CNT_W-1:0] g
	);
		logic [adc_ctrl_pkg::EDGE_CNT_W-1:0] b;
		b = '0;
		b[adc_ctrl_pkg::EDGE_CNT_W-1] = g[adc_ctrl_pkg::EDGE_CNT_W-1];
		for (int i = adc_ctrl_pkg::EDGE_CNT_W - 2; i >= 0; i--) begin
			b[i] = b[i+1] ^ g[i];
		end
		return b;
	endfunction

	assign pins_raw = {supply_ok, chain_mode, readout_select_or_chain_input, conversion_start};

	sync2 #(
		.WIDTH (4)
	) u_pin_sync (
		.clk    (clk_sys),
		.arst_n (arst_n),
		.d      (pins_raw),
		.q      (pins_s)
	);

	assign cnv_s    = pins_s[0];
	assign sel_s    = pins_s[1];
	assign chain_s  = pins_s[2];
	assign supply_s = pins_s[3];

	sync2 #(
		.WIDTH (adc_ctrl_pkg::EDGE_CNT_W)
	) u_edge_sync (
		.clk    (clk_sys),
		.arst_n (arst_n),
		.d      (edge_gray),
		.q      (gray_s)
	);

	// Edge detection on synchronised inputs
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			cnv_prev_r  <= 1'b0;
			gray_prev_r <= '0;
		end else begin
			cnv_prev_r  <= cnv_s;
			gray_prev_r <= gray_s;
		end
	end

	assign cnv_rise  = cnv_s & ~cnv_prev_r;
	assign sck_edge  = (gray_s != gray_prev_r);
	assign conv_done = (state_r == adc_ctrl_pkg::ST_CONV) && (conv_cnt_r == CONV_LAST);
	assign por_done  = (por_cnt_r == adc_ctrl_pkg::POR_CNT_W'(POR_WAIT_CYCLES - 1));

	// Conversion state machine
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			adc_ctrl_pkg::ST_INIT: begin
				if (por_done) begin
					state_nxt = adc_ctrl_pkg::ST_ACQ;
				end
			end
			adc_ctrl_pkg::ST_ACQ: begin
				if (cnv_rise) begin
					state_nxt = adc_ctrl_pkg::ST_CONV;
				end
			end
			adc_ctrl_pkg::ST_CONV: begin
				// Start edges are not looked at here
				if (conv_done) begin
					if (sleep_req_r) begin
						state_nxt = adc_ctrl_pkg::ST_SLEEP;
					end else begin
						state_nxt = adc_ctrl_pkg::ST_ACQ;
					end
				end
			end
			adc_ctrl_pkg::ST_SLEEP: begin
				if (sck_edge) begin
					state_nxt = adc_ctrl_pkg::ST_ACQ;
				end
			end
			default: begin
				state_nxt = adc_ctrl_pkg::ST_INIT;
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			state_r <= adc_ctrl_pkg::ST_INIT;
		end else if (!supply_s) begin
			state_r <= adc_ctrl_pkg::ST_INIT;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Re-initialisation wait after reset or supply dip
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			por_cnt_r <= '0;
		end else if (!supply_s || state_r != adc_ctrl_pkg::ST_INIT) begin
			por_cnt_r <= '0;
		end else if (!por_done) begin
			por_cnt_r <= por_cnt_r + 14'h0001;
		end
	end

	// Self-timed conversion length
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			conv_cnt_r <= '0;
		end else if (state_r == adc_ctrl_pkg::ST_CONV) begin
			conv_cnt_r <= conv_cnt_r + 5'h01;
		end else begin
			conv_cnt_r <= '0;
		end
	end

	// Two start pulses with no shift clock edge between them request sleep
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			pulse_cnt_r <= 2'h0;
		end else if (cnv_rise && pulse_cnt_r == 2'h1 && !sck_edge) begin
			pulse_cnt_r <= 2'h0;
		end else if (cnv_rise) begin
			pulse_cnt_r <= 2'h1;
		end else if (sck_edge || state_r == adc_ctrl_pkg::ST_INIT) begin
			pulse_cnt_r <= 2'h0;
		end
	end

	// Request set wins over the clear at sleep entry
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			sleep_req_r <= 1'b0;
		end else if (cnv_rise && pulse_cnt_r == 2'h1 && !sck_edge) begin
			sleep_req_r <= 1'b1;
		end else if (state_nxt == adc_ctrl_pkg::ST_SLEEP || state_r == adc_ctrl_pkg::ST_INIT) begin
			sleep_req_r <= 1'b0;
		end
	end

	// Result and link edge mark taken as busy falls
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			result_r <= adc_ctrl_pkg::RESULT_RST;
			mark_r   <= '0;
		end else if (conv_done) begin
			result_r <= sar_result;
			mark_r   <= gray2bin(gray_s);
		end
	end

	// Output enable from the select pin or chain mode
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			oe_n_r  <= 1'b1;
			chain_r <= 1'b0;
		end else begin
			chain_r <= chain_s;
			oe_n_r  <= chain_s ? 1'b0 : sel_s;
		end
	end

	// Serial shifter stays alive through sleep
	link_shifter u_link (
		.sck        (sck),
		.arst_n     (arst_n),
		.sdi        (readout_select_or_chain_input),
		.sdo        (sdo),
		.chain_mode (chain_r),
		.result     (result_r),
		.mark       (mark_r),
		.edge_gray  (edge_gray)
	);

	assign busy          = (state_r == adc_ctrl_pkg::ST_CONV);
	assign core_power_on = (state_r == adc_ctrl_pkg::ST_CONV);
	assign standby       = (state_r == adc_ctrl_pkg::ST_SLEEP);
	assign init_done     = (state_r != adc_ctrl_pkg::ST_INIT);
	assign sdo_oe_n      = oe_n_r;

endmodule

// >>> test/adc_conv_ctrl_props.sv
// Concurrent checks on the converter control ports
`timescale 1ns/100ps
module adc_conv_ctrl_props #(
	parameter int unsigned POR_WAIT_CYCLES = 20
) (
	// Clocks, reset and pins
	input wire logic	clk_sys,
	input wire logic	arst_n,
	input wire logic	sck,
	input wire logic	conversion_start,
	input wire logic	readout_select_or_chain_input,
	input wire logic	chain_mode,
	input wire logic	supply_ok,
	input wire logic [15:0]	sar_result,
	// Outputs of the block
	input wire logic	core_power_on,
	input wire logic	standby,
	input wire logic	init_done,
	input wire logic	busy,
	input wire logic	sdo,
	input wire logic	sdo_oe_n
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!arst_n);
	localparam logic [7:0]	CONV = 8'(adc_ctrl_pkg::CONV_CYCLES);
	logic [7:0]	busy_cnt_r;
	// Length of the running conversion
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) busy_cnt_r <= 8'h00;
		else busy_cnt_r <= busy ? busy_cnt_r + 8'h01 : 8'h00;
	end
	sequence s_idle_start; $rose(conversion_start) && init_done && !busy && !standby; endsequence
	sequence s_conv_end; $fell(busy) && init_done; endsequence
	property p_start; s_idle_start |-> ##[1:5] busy; endproperty
	a_start: assert property (p_start) else $error("start edge gave no conversion");
	property p_core; core_power_on == busy; endproperty
	a_core: assert property (p_core) else $error("core power differs from busy");
	property p_len; s_conv_end |-> busy_cnt_r == CONV; endproperty
	a_len: assert property (p_len) else $error("conversion length wrong");
	property p_max; busy |-> busy_cnt_r < CONV; endproperty
	a_max: assert property (p_max) else $error("conversion too long");
	property p_sleep; $rose(standby) |-> $fell(busy); endproperty
	a_sleep: assert property (p_sleep) else $error("sleep entered off busy fall");
	property p_wake; standby && $rose(sck) |-> ##[1:6] !standby; endproperty
	a_wake: assert property (p_wake) else $error("shift clock did not wake");
	property p_oe_off; (!chain_mode && readout_select_or_chain_input) [*6] |-> sdo_oe_n; endproperty
	a_oe_off: assert property (p_oe_off) else $error("output driven while deselected");
	property p_oe_on; (chain_mode || !readout_select_or_chain_input) [*6] |-> !sdo_oe_n; endproperty
	a_oe_on: assert property (p_oe_on) else $error("output not driven");
	property p_msb; s_conv_end ##0 (!sdo_oe_n && !standby) |-> (sdo == sar_result[15]) [*3];
	endproperty
	a_msb: assert property (p_msb) else $error("msb not shown at busy fall");
	property p_init; !init_done |-> !busy; endproperty
	a_init: assert property (p_init) else $error("conversion during init");
endmodule

bind adc_conv_ctrl adc_conv_ctrl_props #(.POR_WAIT_CYCLES(POR_WAIT_CYCLES)) u_props (
	.clk_sys, .arst_n, .sck, .conversion_start, .readout_select_or_chain_input, .chain_mode,
	.supply_ok, .sar_result, .core_power_on, .standby, .init_done, .busy, .sdo, .sdo_oe_n);

// >>> test/host_model.sv
// Host model: start pin, shift clock and select line
`timescale 1ns/100ps
module host_model (
	// Pacing clock
	input wire logic	clk_sys,
	// Serial output of the converter
	input wire logic	sdo,
	input wire logic	sdo_oe_n,
	// Pins toward the converter
	output logic	conversion_start,
	output logic	sck,
	output logic	readout_select_or_chain_input
);
	initial begin
		conversion_start = 1'h0;
		sck = 1'h0;
		readout_select_or_chain_input = 1'h0;
	end
	// Single clean pulse, no extra edges
	task automatic pulse_start();
		@(posedge clk_sys);
		#2;
		conversion_start = 1'h1;
		@(posedge clk_sys);
		#2;
		conversion_start = 1'h0;
	endtask
	// Lone rise straddling a system edge
	task automatic tick();
		@(posedge clk_sys);
		#6;
		sck = 1'h1;
		#16;
		sck = 1'h0;
	endtask
	task automatic set_select(input logic v);
		@(posedge clk_sys);
		#2;
		readout_select_or_chain_input = v;
	endtask
	// Bit sampled before each rise, upstream bits fed before rises
	task automatic read_frame(input logic [15:0] up, output logic [31:0] q);
		@(posedge clk_sys);
		#2;
		for (int i = 0; i < 32; i++) begin
			q[31-i] = sdo_oe_n ? 1'hz : sdo;
			if (i < 16) readout_select_or_chain_input = up[15-i];
			#16;
			sck = 1'h1;
			#16;
			sck = 1'h0;
		end
	endtask
endmodule

// >>> test/tb_bipolar_sar_adc_serial_control.sv
// Self-checking bench for the converter control block
`timescale 1ns/100ps
module tb_bipolar_sar_adc_serial_control;
	logic	clk_sys, arst_n, chain_mode, supply_ok;
	logic [15:0]	sar_result;
	wire	sck, conversion_start, readout_select_or_chain_input;
	wire	core_power_on, standby, init_done, busy, sdo, sdo_oe_n;
	int	fails, comparisons;
	adc_conv_ctrl #(.POR_WAIT_CYCLES(20)) uut (.clk_sys, .arst_n, .sck, .conversion_start,
		.readout_select_or_chain_input, .chain_mode, .supply_ok, .sar_result,
		.core_power_on, .standby, .init_done, .busy, .sdo, .sdo_oe_n);
	host_model u_host (.clk_sys, .sdo, .sdo_oe_n, .conversion_start, .sck,
		.readout_select_or_chain_input);
	initial begin
		clk_sys = 1'h0;
		forever #10 clk_sys = ~clk_sys;
	end
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic test_done();
		if (fails == 0 && comparisons > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
		#2;
	endtask
	task automatic wait_init();
		int n;
		n = 0;
		while (init_done !== 1'h1 && n < 60) begin
			cyc(1);
			n++;
		end
		check("init done", init_done, 1'h1);
	endtask
	// Waits for busy, then counts its cycles
	task automatic run_conv(output int n);
		n = 0;
		while (busy !== 1'h1 && n < 10) begin
			cyc(1);
			n++;
		end
		n = 0;
		while (busy === 1'h1 && n < 40) begin
			cyc(1);
			n++;
		end
	endtask
	task automatic t_conv(input logic [15:0] val, input logic [15:0] up);
		int n;
		logic [31:0] q;
		sar_result = val;
		u_host.pulse_start();
		run_conv(n);
		check("conv cycles", n, adc_ctrl_pkg::CONV_CYCLES);
		check("core off", core_power_on, 1'h0);
		cyc(4);
		u_host.read_frame(up, q);
		check("frame", q, {val, up});
		cyc(24);
	endtask
	task automatic t_sleep();
		int n;
		u_host.pulse_start();
		run_conv(n);
		cyc(24);
		u_host.pulse_start();
		run_conv(n);
		check("second conv", n, adc_ctrl_pkg::CONV_CYCLES);
		check("sleep entry", standby, 1'h1);
		u_host.pulse_start();
		cyc(8);
		check("start in sleep", busy, 1'h0);
		u_host.tick();
		cyc(6);
		check("wake", standby, 1'h0);
		cyc(10);
	endtask
	task automatic t_select();
		u_host.set_select(1'h1);
		cyc(6);
		check("oe off", sdo_oe_n, 1'h1);
		u_host.set_select(1'h0);
		cyc(6);
		check("oe on", sdo_oe_n, 1'h0);
		chain_mode = 1'h1;
		u_host.set_select(1'h1);
		cyc(6);
		check("chain oe", sdo_oe_n, 1'h0);
		t_conv(16'h5A3C, 16'hC3A5);
		chain_mode = 1'h0;
		u_host.set_select(1'h0);
		cyc(6);
	endtask
	task automatic t_supply();
		u_host.pulse_start();
		cyc(6);
		check("busy", busy, 1'h1);
		supply_ok = 1'h0;
		cyc(4);
		check("drop busy", busy, 1'h0);
		check("drop init", init_done, 1'h0);
		supply_ok = 1'h1;
		wait_init();
	endtask
	initial begin
		fails = 0;
		comparisons = 0;
		arst_n = 1'h0;
		chain_mode = 1'h0;
		supply_ok = 1'h1;
		sar_result = 16'h0000;
		repeat (12) @(posedge clk_sys);
		#2;
		arst_n = 1'h1;
		u_host.pulse_start();
		cyc(8);
		check("start in init", busy, 1'h0);
		wait_init();
		u_host.tick();
		cyc(4);
		t_conv(16'h8001, 16'h0000);
		t_conv(16'h7FFE, 16'h0000);
		t_sleep();
		t_select();
		t_supply();
		test_done();
	end
	initial begin
		#60000;
		fails++;
		test_done();
	end
endmodule
